/* File: rtl/srt_pkg.sv */
// Package for the stereo result timestamper: constants, modes and carriers.
// Assumes a single 40 MHz clock domain.
package srt_pkg;
  localparam int CLK_MHZ = 40;
  localparam int US_NS = 1000;
  localparam int CLK_NS = 25;
  localparam int TICK_CYC = US_NS / CLK_NS;
  localparam int TICK_W = 6;
  localparam int DISP_W = 12;
  localparam int FRAC_W = 4;
  localparam logic [11:0] DISP_INVALID = 12'hFFF;
  localparam logic [11:0] DISP_MAX_VALID = 12'hFFE;
  localparam int TS_W = 64;
  localparam int SEQ_W = 32;
  localparam int PIX_W = 8;
  localparam int Q_W = 32;
  localparam logic [63:0] TS_RST = 64'h0000000000000000;
  localparam logic [31:0] SEQ_RST = 32'h00000000;

  typedef enum logic {
    SRT_LATCH_TRIGGER,
    SRT_LATCH_ARRIVAL
  } srt_latch_e;

  typedef struct packed {
    logic [15:0] col;
    logic [15:0] row;
    logic [PIX_W-1:0] left_pix;
    logic [15:0] disp_raw;
    logic disp_bad;
  } srt_pix_in_s;

  typedef struct packed {
    logic [15:0] col;
    logic [15:0] row;
    logic [PIX_W-1:0] left_pix;
    logic [DISP_W-1:0] disp;
  } srt_pix_out_s;

  typedef struct packed {
    logic signed [TS_W-1:0] stamp;
    logic [SEQ_W-1:0] seq;
    logic [16*Q_W-1:0] q_matrix;
    logic send_left;
  } srt_hdr_s;
endpackage : srt_pkg

/* File: rtl/srt_top.sv */
// Stereo result timestamper: formats disparity pixels, stamps each set.
// Assumes rectified left-grid pixels arrive from an upstream matcher
// on the same clock; the PPS pin and rst_n are asynchronous.
//
// Overview of operation
// - Disparity word is 12-bit unsigned, low four bits fractional.
// - Erroneous pixels get all-ones code; valid values never reach it.
// - One output entry per left-image pixel, left camera grid.
// - Entry holds only horizontal offset; no vertical field exists.
// - Input pixels are assumed rectified upstream before this stage.
// - Rectified left pixel is sent alongside disparity by default.
// - Calibration mapping matrix goes out with every disparity map.
// - Every set header carries a timestamp and a sequence number.
// - Microsecond stamp latched at trigger or arrival per config.
// - Network-sourced sets pass received stamp and sequence unchanged.
// - Time-server alignment loads epoch microseconds into the counter.
// - Counter starts at zero after power-up.
// - PPS rising edge clears the counter in PPS mode.
// - Clear between capture and output yields negative stamp.
// - Negative stamp is capture time minus sync edge time.
// - PPS edges only honoured while PPS sync is enabled.
`timescale 1ns/1ps
`default_nettype none
module srt_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Configuration
  input wire logic pps_enable,
  input wire srt_pkg::srt_latch_e latch_mode,
  input wire logic send_left_en,
  input wire logic [16*srt_pkg::Q_W-1:0] q_matrix,
  // Time server alignment
  input wire logic time_load,
  input wire logic signed [srt_pkg::TS_W-1:0] time_load_val,
  // Sync pin
  input wire logic pps_pin,
  // Frame events
  input wire logic trigger_pulse,
  input wire logic frame_arrive,
  input wire logic set_start,
  input wire logic net_source,
  input wire logic signed [srt_pkg::TS_W-1:0] net_stamp,
  input wire logic [srt_pkg::SEQ_W-1:0] net_seq,
  // Pixel stream in
  input wire logic pix_valid,
  input wire srt_pkg::srt_pix_in_s pix_in,
  // Result out
  output logic hdr_valid,
  output srt_pkg::srt_hdr_s hdr_out,
  output logic out_valid,
  output srt_pkg::srt_pix_out_s pix_out,
  output logic signed [srt_pkg::TS_W-1:0] time_now
);
  logic [1:0] rst_sync_q;
  logic rst_ok_n;
  logic [2:0] pps_sync_q;
  logic pps_rise;
  logic [srt_pkg::TICK_W-1:0] tick_cnt_q;
  logic tick_us;
  logic signed [srt_pkg::TS_W-1:0] time_q;
  logic signed [srt_pkg::TS_W-1:0] cap_q;
  logic [srt_pkg::SEQ_W-1:0] seq_q;
  logic sync_evt;
  logic cap_evt;

  function automatic logic [11:0] enc_disp(input logic [15:0] raw,
                                           input logic bad);
    // Saturate below the invalid code so a real value never aliases it
    if (bad) begin
      enc_disp = srt_pkg::DISP_INVALID;
    end else if (raw > 16'(srt_pkg::DISP_MAX_VALID)) begin
      enc_disp = srt_pkg::DISP_MAX_VALID;
    end else begin
      enc_disp = raw[11:0];
    end
  endfunction : enc_disp

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'h1};
    end
  end
  assign rst_ok_n = rst_sync_q[1];

  // Bit 0 is the metastability stage; edge logic reads bits 1 and 2 only
  always_ff @(posedge mclk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      pps_sync_q <= 3'h0;
    end else begin
      pps_sync_q <= {pps_sync_q[1:0], pps_pin};
    end
  end
  assign pps_rise = pps_sync_q[1] & ~pps_sync_q[2] & pps_enable;
  assign sync_evt = pps_rise | time_load;

  always_ff @(posedge mclk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      tick_cnt_q <= '0;
    end else if (tick_us || sync_evt) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 6'h01;
    end
  end
  assign tick_us = (tick_cnt_q == 6'(srt_pkg::TICK_CYC - 1));

  always_ff @(posedge mclk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      time_q <= srt_pkg::TS_RST;
    end else if (time_load) begin
      time_q <= time_load_val;
    end else if (pps_rise) begin
      time_q <= srt_pkg::TS_RST;
    end else if (tick_us) begin
      time_q <= time_q + 64'sh1;
    end
  end

  // A sync edge while a set is pending shifts its capture time by the
  // counter value lost, making the stamp negative as intended.
  assign cap_evt = (latch_mode == srt_pkg::SRT_LATCH_TRIGGER)
    ? trigger_pulse : frame_arrive;

  always_ff @(posedge mclk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      cap_q <= srt_pkg::TS_RST;
    end else if (cap_evt) begin
      cap_q <= sync_evt ? srt_pkg::TS_RST : time_q;
    end else if (pps_rise && !time_load) begin
      cap_q <= cap_q - time_q;
    end else if (time_load) begin
      cap_q <= cap_q - time_q + time_load_val;
    end
  end

  always_ff @(posedge mclk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      seq_q <= srt_pkg::SEQ_RST;
    end else if (set_start && !net_source) begin
      seq_q <= seq_q + 32'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      hdr_valid <= 1'h0;
      hdr_out <= '0;
    end else begin
      hdr_valid <= set_start;
      if (set_start) begin
        hdr_out.stamp <= net_source ? net_stamp : cap_q;
        hdr_out.seq <= net_source ? net_seq : seq_q;
        hdr_out.q_matrix <= q_matrix;
        hdr_out.send_left <= send_left_en;
      end
    end
  end

  // Pixels keep left-grid coordinates; only a horizontal disparity goes out
  always_ff @(posedge mclk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      out_valid <= 1'h0;
      pix_out <= '0;
    end else begin
      out_valid <= pix_valid;
      if (pix_valid) begin
        pix_out.col <= pix_in.col;
        pix_out.row <= pix_in.row;
        pix_out.left_pix <= send_left_en ? pix_in.left_pix : '0;
        pix_out.disp <= enc_disp(pix_in.disp_raw, pix_in.disp_bad);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      time_now <= srt_pkg::TS_RST;
    end else begin
      time_now <= time_q;
    end
  end

  property p_invalid_code;
    @(posedge mclk) disable iff (!rst_ok_n)
      pix_valid && pix_in.disp_bad |=> pix_out.disp == 12'hFFF;
  endproperty
  a_invalid_code: assert property (p_invalid_code)
    else $error("bad pixel not coded invalid");

  property p_valid_not_invalid;
    @(posedge mclk) disable iff (!rst_ok_n)
      pix_valid && !pix_in.disp_bad |=> pix_out.disp != 12'hFFF;
  endproperty
  a_valid_not_invalid: assert property (p_valid_not_invalid)
    else $error("valid pixel uses invalid code");

  property p_disp_pass;
    @(posedge mclk) disable iff (!rst_ok_n)
      pix_valid && !pix_in.disp_bad && pix_in.disp_raw < 16'h0FFF
        |=> pix_out.disp == $past(pix_in.disp_raw[11:0]);
  endproperty
  a_disp_pass: assert property (p_disp_pass)
    else $error("disparity word altered");

  property p_one_entry;
    @(posedge mclk) disable iff (!rst_ok_n)
      pix_valid |=> out_valid && pix_out.col == $past(pix_in.col);
  endproperty
  a_one_entry: assert property (p_one_entry)
    else $error("pixel entry lost");

  property p_pps_clear;
    @(posedge mclk) disable iff (!rst_ok_n)
      pps_rise && !time_load |=> time_q == 64'sh0 ##1 time_now == 64'sh0;
  endproperty
  a_pps_clear: assert property (p_pps_clear)
    else $error("pps did not clear counter");

  property p_pps_gate;
    @(posedge mclk) disable iff (!rst_ok_n)
      !pps_enable && !time_load && !tick_us |=> time_q == $past(time_q);
  endproperty
  a_pps_gate: assert property (p_pps_gate)
    else $error("counter moved with pps disabled");

  property p_us_rate;
    @(posedge mclk) disable iff (!rst_ok_n)
      tick_us && !sync_evt |=> !tick_us [*8];
  endproperty
  a_us_rate: assert property (p_us_rate)
    else $error("microsecond tick too fast");

  property p_tick_step;
    @(posedge mclk) disable iff (!rst_ok_n)
      tick_us && !sync_evt |=> time_q == $past(time_q) + 64'sh1;
  endproperty
  a_tick_step: assert property (p_tick_step)
    else $error("counter step wrong");

  property p_seq_inc;
    @(posedge mclk) disable iff (!rst_ok_n)
      set_start && !net_source |=> seq_q == $past(seq_q) + 32'h1
        && hdr_out.seq == $past(seq_q);
  endproperty
  a_seq_inc: assert property (p_seq_inc)
    else $error("sequence not incremented");

  property p_net_pass;
    @(posedge mclk) disable iff (!rst_ok_n)
      set_start && net_source |=> hdr_out.stamp == $past(net_stamp)
        && hdr_out.seq == $past(net_seq) && hdr_valid;
  endproperty
  a_net_pass: assert property (p_net_pass)
    else $error("network stamp not copied");

  property p_q_sent;
    @(posedge mclk) disable iff (!rst_ok_n)
      set_start |=> hdr_out.q_matrix == $past(q_matrix);
  endproperty
  a_q_sent: assert property (p_q_sent)
    else $error("matrix not attached");

  property p_neg_stamp;
    @(posedge mclk) disable iff (!rst_ok_n)
      pps_rise && !time_load && !trigger_pulse && !frame_arrive
        |=> cap_q == $past(cap_q) - $past(time_q);
  endproperty
  a_neg_stamp: assert property (p_neg_stamp)
    else $error("pending stamp not rebased");
endmodule : srt_top
`default_nettype wire

/* File: tb/srt_host_model.sv */
// Host receiver model: counts result sets and rebuilds the scale term w.
// Assumes results arrive on rising mclk with one-cycle valid pulses.
`timescale 1ns/1ps
`default_nettype none
module srt_host_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Results from the device
  input wire logic hdr_valid,
  input wire srt_pkg::srt_hdr_s hdr_out,
  input wire logic out_valid,
  input wire srt_pkg::srt_pix_out_s pix_out,
  // Host view
  output logic [31:0] hdr_count,
  output logic signed [63:0] w16
);
  logic [16*srt_pkg::Q_W-1:0] q_q;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hdr_count <= 32'h00000000;
      q_q <= '0;
    end else if (hdr_valid) begin
      hdr_count <= hdr_count + 32'h00000001;
      q_q <= hdr_out.q_matrix;
    end
  end

  // Fourth row of Q times (u, v, d, 1), kept times 16 so the fraction of d
  // survives without a divide
  always @(posedge mclk) begin
    if (out_valid) begin
      w16 <= ($signed(q_q[12*32 +: 32]) * $signed({1'b0, pix_out.col})
        + $signed(q_q[13*32 +: 32]) * $signed({1'b0, pix_out.row})
        + $signed(q_q[15*32 +: 32])) * 16
        + $signed(q_q[14*32 +: 32]) * $signed({1'b0, pix_out.disp});
    end
  end
endmodule : srt_host_model
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the result timestamper.
// Assumes srt_top and srt_host_model; inputs change on falling edges.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin \
  err_count++; $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); end end
module testbench;
  logic mclk, rst_n, pps_enable, send_left_en, time_load, pps_pin;
  logic trigger_pulse, frame_arrive, set_start, net_source, pix_valid;
  logic hdr_valid, out_valid;
  srt_pkg::srt_latch_e latch_mode;
  logic [16*srt_pkg::Q_W-1:0] q_matrix;
  logic signed [63:0] time_load_val, net_stamp, time_now, t0, w16;
  logic [31:0] net_seq, hdr_count;
  srt_pkg::srt_pix_in_s pix_in;
  srt_pkg::srt_pix_out_s pix_out;
  srt_pkg::srt_hdr_s hdr_out;
  int err_count = 0;
  int samples_checked = 0;

  srt_top u_srt_top (.mclk(mclk), .rst_n(rst_n), .pps_enable(pps_enable),
    .latch_mode(latch_mode), .send_left_en(send_left_en),
    .q_matrix(q_matrix), .time_load(time_load),
    .time_load_val(time_load_val), .pps_pin(pps_pin),
    .trigger_pulse(trigger_pulse), .frame_arrive(frame_arrive),
    .set_start(set_start), .net_source(net_source), .net_stamp(net_stamp),
    .net_seq(net_seq), .pix_valid(pix_valid), .pix_in(pix_in),
    .hdr_valid(hdr_valid), .hdr_out(hdr_out), .out_valid(out_valid),
    .pix_out(pix_out), .time_now(time_now));
  srt_host_model u_srt_host_model (.mclk(mclk), .rst_n(rst_n),
    .hdr_valid(hdr_valid), .hdr_out(hdr_out), .out_valid(out_valid),
    .pix_out(pix_out), .hdr_count(hdr_count), .w16(w16));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  task automatic t_counter;
    `CHK("time_zero", 64'sh0, time_now)
    for (int i = 0; i < 100 && time_now !== 64'sh1; i++) cyc(1);
    cyc(39);
    `CHK("time_hold", 64'sh1, time_now)
    cyc(1);
    `CHK("time_step", 64'sh2, time_now)
  endtask : t_counter

  task automatic t_pixels;
    logic [15:0] raw [5] = '{16'h0000, 16'h0123, 16'h0FFE, 16'h1234, 16'h0ABC};
    logic [11:0] ex [5] = '{12'h000, 12'h123, 12'hFFE, 12'hFFE, 12'hFFF};
    for (int i = 0; i < 5; i++) begin
      pix_in = '{16'(i), 16'h0007, 8'h5A, raw[i], i == 4};
      pix_valid = 1'b1;
      cyc(1);
      `CHK("out_valid", 1'b1, out_valid)
      `CHK("disp", ex[i], pix_out.disp)
      `CHK("col", 16'(i), pix_out.col)
      `CHK("row", 16'h0007, pix_out.row)
      `CHK("left_pix", 8'h5A, pix_out.left_pix)
    end
    // Outside the default configuration the left pixel is blanked
    send_left_en = 1'b0;
    pix_in.left_pix = 8'hC3;
    cyc(1);
    `CHK("left_off", 8'h00, pix_out.left_pix)
    pix_valid = 1'b0;
    send_left_en = 1'b1;
  endtask : t_pixels

  task automatic hdr(input logic net, input logic [31:0] seq);
    net_source = net;
    set_start = 1'b1;
    cyc(1);
    set_start = 1'b0;
    `CHK("hdr_valid", 1'b1, hdr_valid)
    `CHK("seq", seq, hdr_out.seq)
    `CHK("q", q_matrix, hdr_out.q_matrix)
    `CHK("send_left", send_left_en, hdr_out.send_left)
  endtask : hdr

  task automatic capture(input logic trig);
    t0 = time_now;
    trigger_pulse = trig;
    frame_arrive = !trig;
    cyc(1);
    trigger_pulse = 1'b0;
    frame_arrive = 1'b0;
  endtask : capture

  task automatic t_header;
    logic signed [63:0] t_first;
    for (int m = 0; m < 2; m++) begin
      latch_mode = srt_pkg::srt_latch_e'(m);
      capture(m == 0);
      t_first = t0;
      cyc(100);
      capture(m != 0);
      // The second pulse is of the other kind and must not move the stamp
      t0 = t_first;
      hdr(1'b0, 32'(m));
      `CHK("stamp", 1'b1, hdr_out.stamp - t0 inside {[0:1]})
    end
    // Let an edge pass so set_start is not lowered and raised at once
    cyc(1);
    hdr(1'b1, net_seq);
    `CHK("net_stamp", net_stamp, hdr_out.stamp)
  endtask : t_header

  task automatic t_sync;
    time_load_val = 64'sh0005_E000_0000_0000;
    time_load = 1'b1;
    cyc(1);
    time_load = 1'b0;
    cyc(3);
    `CHK("load", 1'b1, time_now - time_load_val inside {[0:1]})
    pps_pin = 1'b1;
    cyc(5);
    pps_pin = 1'b0;
    `CHK("pps_off", 1'b1, time_now >= time_load_val)
    pps_enable = 1'b1;
    latch_mode = srt_pkg::SRT_LATCH_TRIGGER;
    capture(1'b1);
    cyc(200);
    pps_pin = 1'b1;
    cyc(6);
    `CHK("pps_clear", 64'sh0, time_now)
    hdr(1'b0, 32'h00000002);
    `CHK("neg", 1'b1, hdr_out.stamp inside {[-6:-4]})
    // Col 2, row 7, disparity 2.0 against matrix row 0x100C..0x100F
    pix_in = '{16'h0002, 16'h0007, 8'h5A, 16'h0020, 1'b0};
    pix_valid = 1'b1;
    cyc(1);
    pix_valid = 1'b0;
    cyc(1);
    `CHK("w16", 64'sh00000000000C09E0, w16)
  endtask : t_sync

  task automatic close_out;
    $display("Checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  initial begin
    {rst_n, pps_enable, time_load, pps_pin, trigger_pulse} = 5'h0;
    {frame_arrive, set_start, net_source, pix_valid} = 4'h0;
    send_left_en = 1'b1;
    latch_mode = srt_pkg::SRT_LATCH_TRIGGER;
    for (int i = 0; i < 16; i++) q_matrix[i*32 +: 32] = 32'h1000 + i;
    time_load_val = 64'sh0;
    net_stamp = 64'sh8000_0000_0000_0123;
    net_seq = 32'hA5A50001;
    pix_in = '0;
    cyc(5);
    rst_n = 1'b1;
    cyc(5);
    t_counter();
    t_pixels();
    t_header();
    t_sync();
    cyc(2);
    `CHK("host_sets", 32'h00000004, hdr_count)
    close_out();
  end

  // Run needs about 520 cycles; a hang is cut well past that
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    close_out();
  end
endmodule : testbench
`default_nettype wire
